// file: hw/tsense_map.svh
// Register map, field positions and timing constants of the thermometer control block
// Operation
// - Status read clears flags; persisting faults reassert
// - Status read leaves alert latch untouched
// - Config bit 7 masks all alert assertions
// - Config bit 6 stops conversion, enters standby
// - Status bit 7 shows conversion busy
// - Status bits 6..3 show four limit alarms
// - Status bit 2 shows open remote diode
// - Status bits 1 and 0 read zero
// - Limit and fault flags sticky, reset to zero
// - Rate code 0..7 doubles from 0.0625 Hz; code 7 converts only at the code 6 rate, as a conversion outlasts its interval
// - Rate byte resets to 0.25 Hz code
// - Only three low rate bits are decoded
// - Interval timer within a quarter of nominal
// - Results valid one conversion time after start
// - One-shot during conversion is ignored
// - Rate change restarts interval to new period
// - Identity registers read code, high byte zero
// - One slave address from nine strap values
// - Straps sampled only at reset and software reset
// - Also answer the alert response address
// - Threshold reached sets flag and raises alert
// - Alert latch cleared by alert response read or software reset
`ifndef TSENSE_MAP_SVH
`define TSENSE_MAP_SVH
`define CMD_RD_LOCAL 8'h00
`define CMD_RD_REMOTE 8'h01
`define CMD_RD_STATUS 8'h02
`define CMD_RD_CONFIG 8'h03
`define CMD_RD_RATE 8'h04
`define CMD_WR_CONFIG 8'h09
`define CMD_WR_RATE 8'h0A
`define CMD_ONE_SHOT 8'h0F
`define CMD_SW_RESET 8'hFC
`define CMD_RD_MAKER 8'hFE
`define CMD_RD_PART 8'hFF
`define CFG_MASK_BIT 7
`define CFG_STOP_BIT 6
`define CFG_RESET 8'h00
`define RATE_RESET 8'h02
`define RATE_CODE_W 3
`define ST_BUSY_BIT 7
`define ST_LHI_BIT 6
`define ST_LLO_BIT 5
`define ST_RHI_BIT 4
`define ST_RLO_BIT 3
`define ST_OPEN_BIT 2
`define ALERT_RESP_ADDR 7'h0C
`define CLK_HZ 10000000
`define TICK_HZ 16
`define TICK_DIV (`CLK_HZ / `TICK_HZ)
`define SLOWEST_TICKS 256
`define CONV_TIME_MS 125
`define CONV_CYCLES ((`CONV_TIME_MS * `CLK_HZ) / 1000)
`endif

// file: hw/tsense_pkg.sv
// Types shared by the thermometer control block
package tsense_pkg;
   typedef enum logic [1:0] {CONV_IDLE = 2'b00, CONV_RUN = 2'b01, CONV_DONE = 2'b10} conv_state_e;
   typedef logic [7:0] byte_t;
endpackage : tsense_pkg

// file: hw/tsense_ctrl.sv
// Configuration, status, rate timer and address latch of the thermometer
`timescale 1ns/1ps
`include "tsense_map.svh"
module tsense_ctrl
   import tsense_pkg::*;
#(
   parameter int TICK_DIV = `TICK_DIV,
   parameter int CONV_CYCLES = `CONV_CYCLES,
   parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
   parameter logic [7:0] PART_CODE = 8'hA5 // Arbitrary value
)
(
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_CODE,
   input wire logic [7:0] CMD_WDATA,
   output logic [15:0] RD_DATA,
   input wire logic ARA_READ,
   input wire logic HW_STANDBY_PIN,
   input wire logic [1:0] ADDRESS_STRAP_A,
   input wire logic [1:0] ADDRESS_STRAP_B,
   input wire logic CONV_OK,
   input wire logic LOCAL_OVER,
   input wire logic LOCAL_UNDER,
   input wire logic REMOTE_OVER,
   input wire logic REMOTE_UNDER,
   input wire logic DIODE_OPEN,
   input wire logic [7:0] LOCAL_SAMPLE,
   input wire logic [7:0] REMOTE_SAMPLE,
   output logic [7:0] LOCAL_TEMP_RESULT,
   output logic [7:0] REMOTE_TEMP_RESULT,
   output logic CONV_BUSY,
   output logic [6:0] SLAVE_ADDR,
   output logic [6:0] ALERT_RESP_ADDR,
   output logic ALERT_N_O,
   output logic ALERT_N_OE
);
   // Synchronisers for pin inputs
   logic [1:0] hw_standby_pin_s_r;
   logic [1:0] strap_a_s1_r;
   logic [1:0] strap_a_s2_r;
   logic [1:0] strap_b_s1_r;
   logic [1:0] strap_b_s2_r;
   logic [4:0] flt_s1_r;
   logic [4:0] flt_s2_r;
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         hw_standby_pin_s_r <= 2'h0;
         strap_a_s1_r <= 2'h0;
         strap_a_s2_r <= 2'h0;
         strap_b_s1_r <= 2'h0;
         strap_b_s2_r <= 2'h0;
         flt_s1_r <= 5'h00;
         flt_s2_r <= 5'h00;
      end
      else
      begin
         hw_standby_pin_s_r <= {hw_standby_pin_s_r[0], HW_STANDBY_PIN};
         strap_a_s1_r <= ADDRESS_STRAP_A;
         strap_a_s2_r <= strap_a_s1_r;
         strap_b_s1_r <= ADDRESS_STRAP_B;
         strap_b_s2_r <= strap_b_s1_r;
         flt_s1_r <= {LOCAL_OVER, LOCAL_UNDER, REMOTE_OVER, REMOTE_UNDER, DIODE_OPEN};
         flt_s2_r <= flt_s1_r;
      end
   end
   wire logic hw_standby_pin = hw_standby_pin_s_r[1];

   // Command decode
   wire logic wr_cfg = CMD_VALID && (CMD_CODE == `CMD_WR_CONFIG);
   wire logic wr_rate = CMD_VALID && (CMD_CODE == `CMD_WR_RATE);
   wire logic rd_status = CMD_VALID && (CMD_CODE == `CMD_RD_STATUS);
   wire logic one_shot = CMD_VALID && (CMD_CODE == `CMD_ONE_SHOT);
   wire logic sw_reset = CMD_VALID && (CMD_CODE == `CMD_SW_RESET);

   logic [7:0] cfg_r;
   logic [7:0] rate_r;
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         cfg_r <= `CFG_RESET;
         rate_r <= `RATE_RESET;
      end
      else if (sw_reset)
      begin
         cfg_r <= `CFG_RESET;
         rate_r <= `RATE_RESET;
      end
      else
      begin
         if (wr_cfg)
            cfg_r <= {CMD_WDATA[7:6], 6'h00};
         if (wr_rate)
            rate_r <= CMD_WDATA;
      end
   end
   wire logic mask_alert = cfg_r[`CFG_MASK_BIT];
   wire logic sw_stop = cfg_r[`CFG_STOP_BIT];
   wire logic standby = sw_stop || hw_standby_pin;
   wire logic [`RATE_CODE_W-1:0] rate_code = rate_r[`RATE_CODE_W-1:0];

   // Divider gives a 16 Hz tick, exact so well inside a quarter of nominal
   logic [23:0] div_r;
   logic tick_r;
   wire logic div_end = (div_r == 24'(TICK_DIV - 1));
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         div_r <= 24'h000000;
         tick_r <= 1'b0;
      end
      else
      begin
         div_r <= div_end ? 24'h000000 : div_r + 24'h000001;
         tick_r <= div_end;
      end
   end

   // Interval in ticks: 256 at code 0 halving per code
   wire logic [8:0] interval = 9'(`SLOWEST_TICKS) >> rate_code;

   conv_state_e state_r;
   conv_state_e state_nxt;
   logic [8:0] ival_r;
   logic [23:0] conv_cnt_r;
   logic hw_standby_pin_d_r;
   logic shot_r;
   wire logic ival_hit = tick_r && (ival_r >= interval - 9'h001);
   wire logic hw_standby_pin_fall = hw_standby_pin_d_r && !standby;
   wire logic idle = (state_r == CONV_IDLE);
   wire logic start_req = idle && ((!standby && (ival_hit || hw_standby_pin_fall)) || one_shot);
   wire logic conv_end = (state_r == CONV_RUN) && (conv_cnt_r == 24'(CONV_CYCLES - 1));

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         CONV_IDLE: if (start_req) state_nxt = CONV_RUN;
         CONV_RUN:
         begin
            if (sw_stop && !shot_r)
               state_nxt = CONV_IDLE;
            else if (conv_end)
               state_nxt = CONV_DONE;
         end
         CONV_DONE: state_nxt = CONV_IDLE;
         default: state_nxt = CONV_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_r <= CONV_RUN; // Power-up starts a conversion
         hw_standby_pin_d_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         hw_standby_pin_d_r <= standby;
      end
   end

   // One-shot conversion runs to its end even in software standby
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         shot_r <= 1'b0;
      else if (idle)
         shot_r <= start_req && one_shot;
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         conv_cnt_r <= 24'h000000;
      else
         conv_cnt_r <= (state_r == CONV_RUN && !conv_end) ? conv_cnt_r + 24'h000001 : 24'h000000;
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         ival_r <= 9'h000;
      else if (wr_rate || start_req || sw_reset)
         ival_r <= 9'h000;
      else if (ival_hit)
         ival_r <= 9'h000;
      else if (tick_r)
         ival_r <= ival_r + 9'h001;
   end

   // Results and flags update at the end of a conversion
   wire logic done = (state_r == CONV_DONE) && CONV_OK;
   wire logic [4:0] fault_now = flt_s2_r;
   logic [4:0] flags_r;
   wire logic [4:0] flag_set = done ? fault_now : 5'h00;
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         flags_r <= 5'h00;
      else if (sw_reset)
         flags_r <= 5'h00;
      else if (rd_status)
         flags_r <= flag_set | fault_now;
      else
         flags_r <= flags_r | flag_set;
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         LOCAL_TEMP_RESULT <= 8'h00;
         REMOTE_TEMP_RESULT <= 8'h00;
      end
      else if (done)
      begin
         LOCAL_TEMP_RESULT <= LOCAL_SAMPLE;
         REMOTE_TEMP_RESULT <= REMOTE_SAMPLE;
      end
   end

   // Alert latch, set on new flags, cleared by alert response read or software reset
   logic alert_r;
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         alert_r <= 1'b0;
      else if ((|flag_set) && !mask_alert)
         alert_r <= 1'b1;
      else if (ARA_READ || sw_reset)
         alert_r <= 1'b0;
   end

   // Strap decode: 0 low, 1 open, 2 or 3 high
   wire logic strap_a_gnd = (strap_a_s2_r == 2'h0);
   wire logic strap_a_open = (strap_a_s2_r == 2'h1);
   wire logic [3:0] addr_hi = strap_a_gnd ? 4'h3 : strap_a_open ? 4'h5 : 4'h9;
   wire logic [2:0] addr_lo_base = strap_a_gnd ? 3'h0 : strap_a_open ? 3'h1 : 3'h4;
   wire logic [2:0] addr_lo_ofs = strap_b_s2_r[1] ? 3'h2 : {2'h0, strap_b_s2_r[0]};
   wire logic [2:0] addr_lo = addr_lo_base + addr_lo_ofs;
   wire logic [6:0] strap_addr = {addr_hi, addr_lo};

   logic [1:0] samp_r;
   logic [6:0] addr_r;
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         samp_r <= 2'h3;
      else if (sw_reset)
         samp_r <= 2'h3;
      else if (samp_r != 2'h0)
         samp_r <= samp_r - 2'h1;
   end
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         addr_r <= 7'h00;
      else if (samp_r == 2'h1)
         addr_r <= strap_addr;
   end

   // Read mux
   wire logic [7:0] status = {state_r != CONV_IDLE, flags_r, 2'b00};
   logic [7:0] rd_byte;
   always_comb
   begin
      case (CMD_CODE)
         `CMD_RD_LOCAL: rd_byte = LOCAL_TEMP_RESULT;
         `CMD_RD_REMOTE: rd_byte = REMOTE_TEMP_RESULT;
         `CMD_RD_STATUS: rd_byte = status;
         `CMD_RD_CONFIG: rd_byte = cfg_r;
         `CMD_RD_RATE: rd_byte = rate_r;
         `CMD_RD_MAKER: rd_byte = MAKER_CODE;
         `CMD_RD_PART: rd_byte = PART_CODE;
         default: rd_byte = 8'h00;
      endcase
   end
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         RD_DATA <= 16'h0000;
      else
         RD_DATA <= {8'h00, rd_byte};
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         CONV_BUSY <= 1'b0;
      else
         CONV_BUSY <= (state_r != CONV_IDLE);
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         SLAVE_ADDR <= 7'h00;
      else
         SLAVE_ADDR <= addr_r;
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         ALERT_RESP_ADDR <= 7'h00;
      else
         ALERT_RESP_ADDR <= `ALERT_RESP_ADDR;
   end

   // Open-drain alert: level always low, enable low drives the pin
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ALERT_N_O <= 1'b0;
         ALERT_N_OE <= 1'b1;
      end
      else
      begin
         ALERT_N_O <= 1'b0;
         ALERT_N_OE <= !alert_r;
      end
   end
endmodule : tsense_ctrl

// file: dv/tsense_host.sv
// SMBus host model issuing completed commands to the thermometer
`timescale 1ns/1ps
module tsense_host
(
   input wire logic clk,
   input wire logic [15:0] rd_data,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_wdata,
   output logic ara_read
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 8'h00;
      ara_read = 1'b0;
   end
   // Data comes back registered at the taking edge
   task xfer(input logic [7:0] code, input logic [7:0] wdata, output logic [15:0] rdata);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = code;
      cmd_wdata = wdata;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_wdata = ~wdata;
      rdata = rd_data;
   endtask : xfer
   task alert_read();
      @(negedge clk);
      ara_read = 1'b1;
      @(negedge clk);
      ara_read = 1'b0;
   endtask : alert_read
endmodule : tsense_host

// file: dv/tsense_ctrl_assertions.sv
// Port checks of the thermometer control block
`timescale 1ns/1ps
module tsense_ctrl_assertions
(
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_CODE,
   input wire logic [7:0] CMD_WDATA,
   input wire logic [15:0] RD_DATA,
   input wire logic ARA_READ,
   input wire logic [7:0] LOCAL_TEMP_RESULT,
   input wire logic CONV_BUSY,
   input wire logic [6:0] SLAVE_ADDR,
   input wire logic [6:0] ALERT_RESP_ADDR,
   input wire logic ALERT_N_OE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   logic mask_r;
   logic [2:0] relatch_r;
   wire sw_reset = CMD_VALID && CMD_CODE == 8'hFC;
   wire cfg_write = CMD_VALID && CMD_CODE == 8'h09;
   always_ff @(posedge CLK_SYS or negedge RST_N)
      if (!RST_N)
      begin
         mask_r <= 1'b0;
         relatch_r <= 3'h5;
      end
      else
      begin
         mask_r <= sw_reset ? 1'b0 : cfg_write ? CMD_WDATA[7] : mask_r;
         relatch_r <= sw_reset ? 3'h5 : (relatch_r != 3'h0) ? relatch_r - 3'h1 : relatch_r;
      end
   sequence status_read;
      CMD_VALID && CMD_CODE == 8'h02;
   endsequence
   sequence conv_start;
      $rose(CONV_BUSY);
   endsequence
   AST_HIGH_ZERO: assert property (RD_DATA[15:8] == 8'h00)
      else $error("Read high byte not zero");
   AST_RSV_ZERO: assert property (status_read |=> RD_DATA[1:0] == 2'b00)
      else $error("Status low bits not zero");
   AST_ARA_ADDR: assert property ($past(RST_N) |-> ALERT_RESP_ADDR == 7'h0C)
      else $error("Alert response address wrong");
   AST_ALERT_CLR: assert property ($rose(ALERT_N_OE) |-> $past(ARA_READ, 2) || $past(sw_reset, 2))
      else $error("Alert released without response read");
   AST_MASK: assert property ($fell(ALERT_N_OE) |-> !$past(mask_r, 2))
      else $error("Alert raised while masked");
   AST_CONV_END: assert property (conv_start |-> ##[1:12] !CONV_BUSY)
      else $error("Conversion too long");
   AST_RESULT: assert property ($changed(LOCAL_TEMP_RESULT) |-> $past(CONV_BUSY) || $past(CONV_BUSY, 2))
      else $error("Result changed outside conversion end");
   AST_ADDR_HOLD: assert property ($changed(SLAVE_ADDR) |-> relatch_r != 3'h0)
      else $error("Address changed without reset");
endmodule : tsense_ctrl_assertions
bind tsense_ctrl tsense_ctrl_assertions u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CMD_VALID(CMD_VALID),
   .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA), .RD_DATA(RD_DATA), .ARA_READ(ARA_READ),
   .LOCAL_TEMP_RESULT(LOCAL_TEMP_RESULT), .CONV_BUSY(CONV_BUSY), .SLAVE_ADDR(SLAVE_ADDR),
   .ALERT_RESP_ADDR(ALERT_RESP_ADDR), .ALERT_N_OE(ALERT_N_OE));

// file: dv/temp_sensor_status_config_rate_test.sv
// Self-checking bench for the thermometer control block
`timescale 1ns/1ps
module temp_sensor_status_config_rate_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] strap_a = 2'h1;
   logic [1:0] strap_b = 2'h1;
   logic [4:0] faults = 5'h00;
   logic hw_standby_pin_pin = 1'b0;
   logic seen, alert_o;
   logic [7:0] remote_res;
   logic [6:0] ara_addr;
   logic [15:0] rd_data, rdat;
   logic cmd_valid, ara_read, busy, alert_oe;
   logic [7:0] cmd_code, cmd_wdata, local_res;
   logic [6:0] slave_addr;
   int err_count = 0;
   int checked = 0;
   int n, a, c;
   always #50 clk = ~clk;
   tsense_host host (.clk(clk), .rd_data(rd_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .ara_read(ara_read));
   // Identity codes are arbitrary
   tsense_ctrl #(.TICK_DIV(4), .CONV_CYCLES(10), .MAKER_CODE(8'h3C), .PART_CODE(8'hC3)) dut
   (
      .CLK_SYS(clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata),
      .RD_DATA(rd_data), .ARA_READ(ara_read), .HW_STANDBY_PIN(hw_standby_pin_pin), .ADDRESS_STRAP_A(strap_a),
      .ADDRESS_STRAP_B(strap_b), .CONV_OK(1'b1), .LOCAL_OVER(faults[4]), .LOCAL_UNDER(faults[3]),
      .REMOTE_OVER(faults[2]), .REMOTE_UNDER(faults[1]), .DIODE_OPEN(faults[0]), .LOCAL_SAMPLE(8'h19),
      .REMOTE_SAMPLE(8'h2D), .LOCAL_TEMP_RESULT(local_res), .REMOTE_TEMP_RESULT(remote_res), .CONV_BUSY(busy),
      .SLAVE_ADDR(slave_addr), .ALERT_RESP_ADDR(ara_addr), .ALERT_N_O(alert_o), .ALERT_N_OE(alert_oe)
   );
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wait_busy(input logic level, output int cnt);
      for (cnt = 0; busy !== level && cnt < 2000; cnt++) @(negedge clk);
      chk(16'(cnt < 2000), 16'h0001);
   endtask : wait_busy
   task t_reset();
      wait_busy(1'b1, n);
      wait_busy(1'b0, n);
      @(negedge clk);
      chk({8'h00, local_res}, 16'h0019);
      chk({8'h00, remote_res}, 16'h002D);
      chk({9'h000, ara_addr}, 16'h000C);
      chk({15'h0000, alert_o}, 16'h0000);
      host.xfer(8'h03, 8'h00, rdat);
      chk(rdat, 16'h0000);
      host.xfer(8'h04, 8'h00, rdat);
      chk(rdat, 16'h0002);
      host.xfer(8'hFE, 8'h00, rdat);
      chk(rdat, 16'h003C);
      host.xfer(8'hFF, 8'h00, rdat);
      chk(rdat, 16'h00C3);
      chk({9'h000, slave_addr}, 16'h002A);
      $display("t_reset done");
   endtask : t_reset
   task t_flags();
      host.xfer(8'h09, 8'h40, rdat);
      wait_busy(1'b0, n);
      faults = 5'h1F;
      repeat (3) @(negedge clk);
      host.xfer(8'h0F, 8'h00, rdat);
      wait_busy(1'b1, n);
      wait_busy(1'b0, n);
      faults = 5'h01;
      repeat (3) @(negedge clk);
      host.xfer(8'h02, 8'h00, rdat);
      chk(rdat, 16'h007C);
      host.xfer(8'h02, 8'h00, rdat);
      chk(rdat, 16'h0004);
      chk({15'h0000, alert_oe}, 16'h0000);
      host.alert_read();
      @(negedge clk);
      chk({15'h0000, alert_oe}, 16'h0001);
      $display("t_flags done");
   endtask : t_flags
   task t_mask_oneshot();
      host.xfer(8'h09, 8'hFF, rdat);
      host.xfer(8'h03, 8'h00, rdat);
      chk(rdat, 16'h00C0);
      host.xfer(8'h0F, 8'h00, rdat);
      wait_busy(1'b1, n);
      host.xfer(8'h02, 8'h00, rdat);
      chk(rdat, 16'h0084);
      host.xfer(8'h0F, 8'h00, rdat);
      wait_busy(1'b0, n);
      chk(16'(n < 8), 16'h0001);
      chk({15'h0000, alert_oe}, 16'h0001);
      $display("t_mask_oneshot done");
   endtask : t_mask_oneshot
   task t_stop_rate();
      host.xfer(8'h09, 8'h80, rdat);
      wait_busy(1'b1, n);
      host.xfer(8'h09, 8'hC0, rdat);
      repeat (2) @(negedge clk);
      chk({15'h0000, busy}, 16'h0000);
      host.xfer(8'h09, 8'h80, rdat);
      for (c = 0; c < 7; c++)
      begin
         host.xfer(8'h0A, {5'h1F, 3'(c)}, rdat);
         wait_busy(1'b1, n);
         wait_busy(1'b0, a);
         wait_busy(1'b1, n);
         chk(16'((a + n) * 4 >= 12 * (256 >> c) && (a + n) * 4 <= 20 * (256 >> c)), 16'h0001);
      end
      hw_standby_pin_pin = 1'b1;
      wait_busy(1'b0, n);
      repeat (3) @(negedge clk);
      seen = 1'b0;
      repeat (200) @(negedge clk) seen = seen | busy;
      chk({15'h0000, seen}, 16'h0000);
      hw_standby_pin_pin = 1'b0;
      wait_busy(1'b1, n);
      chk(16'(n < 8), 16'h0001);
      host.xfer(8'h04, 8'h00, rdat);
      chk(rdat, 16'h00FE);
      $display("t_stop_rate done");
   endtask : t_stop_rate
   task t_addr();
      strap_a = 2'h0;
      strap_b = 2'h2;
      repeat (5) @(negedge clk);
      chk({9'h000, slave_addr}, 16'h002A);
      host.xfer(8'hFC, 8'h00, rdat);
      repeat (5) @(negedge clk);
      chk({9'h000, slave_addr}, 16'h001A);
      $display("t_addr done");
   endtask : t_addr
   task final_report();
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_flags();
      t_mask_oneshot();
      t_stop_rate();
      t_addr();
      final_report();
   end
   initial
   begin
      repeat (30000) @(negedge clk);
      err_count++;
      final_report();
   end
endmodule : temp_sensor_status_config_rate_test
